// ===== logic/dpmc_top.sv
// dual-input power mux control with AXI4-Lite registers
// Overview of operation
// - drive on only when port valid, allowed; in reverse mode the host selects a fitted port without presence
// - default turn on drive one, state 01
// - disable-both forces both drives off
// - host swaps port by writing drive state
// - high impedance turns both drives off
// - both present selects port one first
// - reverse power enable sets disable-both
// - overvoltage in reverse mode drops drive only
// - watchdog expiry clears reverse power enable
// - pulldown enable bits switch matching pulldowns
// - bypass plus charge closes all switches
// - bypass fault clears charge, keeps bypass
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dpmc_top #(
  parameter int ADDR_W = 12                      // AXI address width
) (
  input  wire logic              CLOCK,          // 10 MHz system clock
  input  wire logic              NRST,           // synchronous reset, low
  input  wire logic [ADDR_W-1:0] AWADDR,         // write address
  input  wire logic              AWVALID,        // write address valid
  output logic                   AWREADY,        // write address ready
  input  wire logic [31:0]       WDATA,          // write data
  input  wire logic [3:0]        WSTRB,          // write byte strobes
  input  wire logic              WVALID,         // write data valid
  output logic                   WREADY,         // write data ready
  output logic [1:0]             BRESP,          // write response
  output logic                   BVALID,         // write response valid
  input  wire logic              BREADY,         // write response ready
  input  wire logic [ADDR_W-1:0] ARADDR,         // read address
  input  wire logic              ARVALID,        // read address valid
  output logic                   ARREADY,        // read address ready
  output logic [31:0]            RDATA,          // read data
  output logic [1:0]             RRESP,          // read response
  output logic                   RVALID,         // read data valid
  input  wire logic              RREADY,         // read data ready
  input  wire logic              PORT1_PRESENT,  // port one above present level
  input  wire logic              PORT2_PRESENT,  // port two above present level
  input  wire logic              PORT1_INPUT_OVERVOLTAGE_FAULT, // port one over limit
  input  wire logic              PORT2_INPUT_OVERVOLTAGE_FAULT, // port two over limit
  input  wire logic              BUS_NODE_PRESENT,       // bus node already powered
  input  wire logic              BUS_OVERVOLTAGE_FAULT,  // bus node over limit
  input  wire logic              PORT1_POPULATED,        // fet pair one fitted
  input  wire logic              PORT2_POPULATED,        // fet pair two fitted
  input  wire logic              CHARGE_FAULT,           // any protection fault
  input  wire logic              WATCHDOG_EXPIRED,       // same-clock expiry pulse
  output logic                   PORT1_GATE_DRIVE,       // gate drive, pair one
  output logic                   PORT2_GATE_DRIVE,       // gate drive, pair two
  output logic                   BUS_PULLDOWN,           // bus discharge pulldown
  output logic                   PORT1_PULLDOWN,         // port one discharge
  output logic                   PORT2_PULLDOWN,         // port two discharge
  output logic                   BLOCKING_SWITCH,        // bypass blocking switch
  output logic [3:0]             HIGH_SIDE_SWITCHES      // four high-side switches
);

  // true when an address hits the given register word
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [3:0] ofs);
    addr_hit = (a[dpmc_pkg::OFS_W-1:0] == ofs) && (a[ADDR_W-1:dpmc_pkg::OFS_W] == '0);
  endfunction
  // true when an address hits any mapped word
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    addr_mapped = addr_hit(a, dpmc_pkg::CTRL_OFS) || addr_hit(a, dpmc_pkg::DRIVE_OFS)
                  || addr_hit(a, dpmc_pkg::STATUS_OFS);
  endfunction

  // ---------------- pin synchronisers ----------------
  logic [dpmc_pkg::NUM_IN-1:0] pins;       // raw pin vector
  logic [dpmc_pkg::NUM_IN-1:0] s1_reg;     // first stage, feeds s2 only
  logic [dpmc_pkg::NUM_IN-1:0] s2_reg;     // second stage
  logic [dpmc_pkg::NUM_IN-1:0] s3_reg;     // third stage
  logic [dpmc_pkg::NUM_IN-1:0] filt_reg;   // accepted level
  logic [dpmc_pkg::NUM_IN-1:0] filt_next;  // next accepted level
  assign pins = {CHARGE_FAULT, PORT2_POPULATED, PORT1_POPULATED, BUS_OVERVOLTAGE_FAULT,
                 BUS_NODE_PRESENT, PORT2_INPUT_OVERVOLTAGE_FAULT,
                 PORT1_INPUT_OVERVOLTAGE_FAULT, PORT2_PRESENT, PORT1_PRESENT};
  // a bit changes only when stages two and three agree, so one-cycle glitches die
  always_comb
  begin
    filt_next = (s2_reg & s3_reg) | (filt_reg & (s2_reg | s3_reg));
  end
  // synchroniser chain
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      filt_reg <= '0;
    end
    else
    begin
      s1_reg   <= pins;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
    end
  end

  // ---------------- AXI4-Lite slave ----------------
  logic              aw_full_reg, aw_full_next;   // write address held
  logic [ADDR_W-1:0] aw_addr_reg, aw_addr_next;   // held write address
  logic              w_full_reg, w_full_next;     // write data held
  logic [31:0]       w_data_reg, w_data_next;     // held write data
  logic [3:0]        w_strb_reg, w_strb_next;     // held strobes
  logic              bvalid_reg, bvalid_next;     // response pending
  logic [1:0]        bresp_reg, bresp_next;       // response code
  logic              rvalid_reg, rvalid_next;     // read data pending
  logic [31:0]       rdata_reg, rdata_next;       // read data
  logic [1:0]        rresp_reg, rresp_next;       // read response code
  logic              wr_fire;                     // write is carried out now
  logic              wr_ctrl;                     // control word written
  logic              wr_drive;                    // drive word written
  dpmc_pkg::dpmc_ctrl_s wctrl;                    // write data seen as control
  dpmc_pkg::dpmc_ctrl_s ctrl_reg, ctrl_next;      // control bits
  logic [dpmc_pkg::DRV_W-1:0] drv_reg, drv_next;  // gate drive state
  assign AWREADY  = !aw_full_reg;
  assign WREADY   = !w_full_reg;
  assign ARREADY  = !rvalid_reg;
  assign BVALID   = bvalid_reg;
  assign BRESP    = bresp_reg;
  assign RVALID   = rvalid_reg;
  assign RDATA    = rdata_reg;
  assign RRESP    = rresp_reg;
  // both halves held and the last response gone: carry out the write
  assign wr_fire  = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_ctrl  = wr_fire && w_strb_reg[0] && addr_hit(aw_addr_reg, dpmc_pkg::CTRL_OFS);
  assign wr_drive = wr_fire && w_strb_reg[0] && addr_hit(aw_addr_reg, dpmc_pkg::DRIVE_OFS);
  assign wctrl    = dpmc_pkg::dpmc_ctrl_s'(w_data_reg[dpmc_pkg::CTRL_W-1:0]);
  // bus channel next state; address and data are taken in either order
  always_comb
  begin
    aw_full_next = aw_full_reg;
    aw_addr_next = aw_addr_reg;
    w_full_next  = w_full_reg;
    w_data_next  = w_data_reg;
    w_strb_next  = w_strb_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg;
    rdata_next   = rdata_reg;
    rresp_next   = rresp_reg;
    if (AWVALID && !aw_full_reg)
    begin
      aw_full_next = 1'b1;
      aw_addr_next = AWADDR;
    end
    if (WVALID && !w_full_reg)
    begin
      w_full_next = 1'b1;
      w_data_next = WDATA;
      w_strb_next = WSTRB;
    end
    if (bvalid_reg && BREADY)
      bvalid_next = 1'b0;
    if (wr_fire)
    begin
      // unmapped words answer slave error and change nothing
      aw_full_next = 1'b0;
      w_full_next  = 1'b0;
      bvalid_next  = 1'b1;
      bresp_next   = addr_mapped(aw_addr_reg) ? dpmc_pkg::RESP_OKAY : dpmc_pkg::RESP_SLVERR;
    end
    if (rvalid_reg && RREADY)
      rvalid_next = 1'b0;
    if (ARVALID && !rvalid_reg)
    begin
      rvalid_next = 1'b1;
      rresp_next  = dpmc_pkg::RESP_OKAY;
      rdata_next  = '0;
      if (addr_hit(ARADDR, dpmc_pkg::CTRL_OFS))
        rdata_next[dpmc_pkg::CTRL_W-1:0] = ctrl_reg;
      else if (addr_hit(ARADDR, dpmc_pkg::DRIVE_OFS))
        rdata_next[dpmc_pkg::DRV_W-1:0] = drv_reg;
      else if (addr_hit(ARADDR, dpmc_pkg::STATUS_OFS))
        rdata_next[dpmc_pkg::NUM_IN-1:0] = filt_reg;
      else
        rresp_next = dpmc_pkg::RESP_SLVERR;
    end
  end

  // bus channel registers
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
      w_full_reg  <= 1'b0;
      w_data_reg  <= '0;
      w_strb_reg  <= '0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= dpmc_pkg::RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= '0;
      rresp_reg   <= dpmc_pkg::RESP_OKAY;
    end
    else
    begin
      aw_full_reg <= aw_full_next;
      aw_addr_reg <= aw_addr_next;
      w_full_reg  <= w_full_next;
      w_data_reg  <= w_data_next;
      w_strb_reg  <= w_strb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // ---------------- power mux control ----------------
  logic ok1_base;       // port one may carry power, bus node aside
  logic ok2_base;       // port two may carry power, bus node aside
  logic bus_free;       // bus node not yet powered
  logic otg;            // reverse power mode
  logic otg_fault;      // overvoltage while in reverse power mode
  logic bypass_on_reg;  // bypass switches closed
  logic bypass_on_next; // next bypass switch state
  assign otg      = ctrl_reg.reverse_power_enable;
  assign bus_free = !filt_reg[dpmc_pkg::IN_BUS_PRES];
  // turn-on conditions shared by both ports
  assign ok1_base = filt_reg[dpmc_pkg::IN_P1_POP] && filt_reg[dpmc_pkg::IN_P1_PRESENT]
                    && !filt_reg[dpmc_pkg::IN_P1_OVP] && !ctrl_reg.disable_both_drives
                    && !ctrl_reg.high_impedance_enable;
  assign ok2_base = filt_reg[dpmc_pkg::IN_P2_POP] && filt_reg[dpmc_pkg::IN_P2_PRESENT]
                    && !filt_reg[dpmc_pkg::IN_P2_OVP] && !ctrl_reg.disable_both_drives
                    && !ctrl_reg.high_impedance_enable;
  // in reverse mode the port is driven from the far side, so present is not asked
  assign otg_fault = filt_reg[dpmc_pkg::IN_BUS_OVP]
                     || (drv_reg[dpmc_pkg::DRV_P1] && filt_reg[dpmc_pkg::IN_P1_OVP])
                     || (drv_reg[dpmc_pkg::DRV_P2] && filt_reg[dpmc_pkg::IN_P2_OVP]);

  // control bits: software writes, then hardware overrides
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl)
    begin
      ctrl_next = wctrl;
      if (wctrl.reverse_power_enable && !ctrl_reg.reverse_power_enable)
        ctrl_next.disable_both_drives = 1'b1;
    end
    // expiry beats a write in the same cycle; reverse power must not survive it
    if (WATCHDOG_EXPIRED)
      ctrl_next.reverse_power_enable = 1'b0;
    // with bypass already enabled, a fault beats a write so charging cannot restart over a live fault
    if (ctrl_reg.bypass_enable && filt_reg[dpmc_pkg::IN_FAULT])
      ctrl_next.charge_enable = 1'b0;
  end

  // gate drive state: at most one port on at any time
  always_comb
  begin
    drv_next = drv_reg;
    if (ctrl_reg.disable_both_drives || ctrl_reg.high_impedance_enable)
      drv_next = dpmc_pkg::DRV_NONE;
    else if (otg)
    begin
      // reverse mode: only the host selects the output port
      if (otg_fault)
        drv_next = dpmc_pkg::DRV_NONE;
      else if (wr_drive)
      begin
        case (w_data_reg[dpmc_pkg::DRV_W-1:0])
          dpmc_pkg::DRV_NONE: drv_next = dpmc_pkg::DRV_NONE;
          dpmc_pkg::DRV_ONE:  drv_next = filt_reg[dpmc_pkg::IN_P1_POP] ? dpmc_pkg::DRV_ONE
                                                                     : drv_reg;
          dpmc_pkg::DRV_TWO:  drv_next = filt_reg[dpmc_pkg::IN_P2_POP] ? dpmc_pkg::DRV_TWO
                                                                     : drv_reg;
          default:            drv_next = drv_reg;  // both on is never accepted
        endcase
      end
    end
    else if (wr_drive && ok1_base && ok2_base
             && (w_data_reg[dpmc_pkg::DRV_W-1:0] == dpmc_pkg::DRV_ONE
                 || w_data_reg[dpmc_pkg::DRV_W-1:0] == dpmc_pkg::DRV_TWO))
      drv_next = w_data_reg[dpmc_pkg::DRV_W-1:0];
    else if (drv_reg[dpmc_pkg::DRV_P1] && !ok1_base)
      drv_next = dpmc_pkg::DRV_NONE;
    else if (drv_reg[dpmc_pkg::DRV_P2] && !ok2_base)
      drv_next = dpmc_pkg::DRV_NONE;
    else if (drv_reg == dpmc_pkg::DRV_NONE && bus_free)
    begin
      // port one ranks first when both inputs qualify
      if (ok1_base)
        drv_next = dpmc_pkg::DRV_ONE;
      else if (ok2_base)
        drv_next = dpmc_pkg::DRV_TWO;
    end
  end

  // bypass path closes only while charging is enabled
  always_comb
  begin
    bypass_on_next = ctrl_reg.bypass_enable && ctrl_reg.charge_enable;
  end

  // control registers
  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      ctrl_reg      <= dpmc_pkg::CTRL_RESET;
      drv_reg       <= dpmc_pkg::DRV_NONE;
      bypass_on_reg <= 1'b0;
    end
    else
    begin
      ctrl_reg      <= ctrl_next;
      drv_reg       <= drv_next;
      bypass_on_reg <= bypass_on_next;
    end
  end

  // outputs straight from flip-flops
  assign PORT1_GATE_DRIVE   = drv_reg[dpmc_pkg::DRV_P1];
  assign PORT2_GATE_DRIVE   = drv_reg[dpmc_pkg::DRV_P2];
  assign BUS_PULLDOWN       = ctrl_reg.bus_pulldown_enable;
  assign PORT1_PULLDOWN     = ctrl_reg.port_one_pulldown_enable;
  assign PORT2_PULLDOWN     = ctrl_reg.port_two_pulldown_enable;
  assign BLOCKING_SWITCH    = bypass_on_reg;
  assign HIGH_SIDE_SWITCHES = {dpmc_pkg::NUM_HIGH_SIDE{bypass_on_reg}};

  // ---------------- checks ----------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  gate_on_cond_a: assert property ($rose(PORT1_GATE_DRIVE) && !$past(otg)
    |-> $past(ok1_base)) else $error("drive one on without its conditions");
  default_port1_a: assert property (drv_reg == dpmc_pkg::DRV_NONE && ok1_base && bus_free
    && !otg && !wr_drive |=> PORT1_GATE_DRIVE && !PORT2_GATE_DRIVE)
    else $error("default drive one not taken");
  disable_both_a: assert property (ctrl_reg.disable_both_drives
    |=> drv_reg == dpmc_pkg::DRV_NONE) else $error("drive on while disabled");
  host_swap_a: assert property (wr_drive && !otg && ok1_base && ok2_base
    && w_data_reg[dpmc_pkg::DRV_W-1:0] == dpmc_pkg::DRV_TWO
    |=> drv_reg == dpmc_pkg::DRV_TWO) else $error("host swap ignored");
  hiz_off_a: assert property (ctrl_reg.high_impedance_enable
    |=> !PORT1_GATE_DRIVE && !PORT2_GATE_DRIVE) else $error("drive on in hiz");
  one_port_a: assert property (drv_reg != dpmc_pkg::DRV_BOTH)
    else $error("both drives on");
  otg_entry_a: assert property (wr_ctrl && wctrl.reverse_power_enable && !otg
    |=> ctrl_reg.disable_both_drives ##1 drv_reg == dpmc_pkg::DRV_NONE)
    else $error("reverse entry did not disable drives");
  otg_fault_a: assert property (otg && filt_reg[dpmc_pkg::IN_BUS_OVP] && !wr_ctrl
    && !WATCHDOG_EXPIRED |=> drv_reg == dpmc_pkg::DRV_NONE && otg)
    else $error("reverse fault handling wrong");
  watchdog_a: assert property (WATCHDOG_EXPIRED |=> !otg)
    else $error("watchdog left reverse power on");
  pulldown_a: assert property (wr_ctrl && wctrl.bus_pulldown_enable && !bvalid_reg
    |=> BUS_PULLDOWN [*1] ##0 PORT1_PULLDOWN == $past(wctrl.port_one_pulldown_enable))
    else $error("pulldown not switched");
  bypass_on_a: assert property (ctrl_reg.bypass_enable && ctrl_reg.charge_enable
    |=> BLOCKING_SWITCH && HIGH_SIDE_SWITCHES == '1) else $error("bypass open");
  bypass_fault_a: assert property (ctrl_reg.bypass_enable && filt_reg[dpmc_pkg::IN_FAULT]
    && !wr_ctrl |=> !ctrl_reg.charge_enable && ctrl_reg.bypass_enable)
    else $error("bypass fault handling wrong");

endmodule

`default_nettype wire

// ===== logic/dpmc_pkg.sv
// shared constants and types for the dual-input power mux control block
package dpmc_pkg;

  // register word offsets (byte addresses, one aligned 32-bit word each)
  localparam int            DATA_W      = 32;
  localparam int            OFS_W       = 4;
  localparam logic [3:0]    CTRL_OFS    = 4'h0;   // control bits
  localparam logic [3:0]    DRIVE_OFS   = 4'h4;   // gate drive state, read and write
  localparam logic [3:0]    STATUS_OFS  = 4'h8;   // filtered pin levels, read only

  // control register layout, lowest field is bit 0
  localparam int CTRL_W = 8;
  typedef struct packed {
    logic bypass_enable;             // bit 7
    logic charge_enable;             // bit 6
    logic port_two_pulldown_enable;  // bit 5
    logic port_one_pulldown_enable;  // bit 4
    logic bus_pulldown_enable;       // bit 3
    logic reverse_power_enable;      // bit 2
    logic high_impedance_enable;     // bit 1
    logic disable_both_drives;       // bit 0
  } dpmc_ctrl_s;
  localparam dpmc_ctrl_s CTRL_RESET = 8'h00;

  // drive state register layout
  localparam int         DRV_W     = 2;
  localparam int         DRV_P1    = 0;
  localparam int         DRV_P2    = 1;
  localparam logic [1:0] DRV_NONE  = 2'h0;
  localparam logic [1:0] DRV_ONE   = 2'h1;
  localparam logic [1:0] DRV_TWO   = 2'h2;
  localparam logic [1:0] DRV_BOTH  = 2'h3;

  // bit positions of the pin inputs inside the filtered vector and status word
  localparam int IN_P1_PRESENT = 0;
  localparam int IN_P2_PRESENT = 1;
  localparam int IN_P1_OVP     = 2;
  localparam int IN_P2_OVP     = 3;
  localparam int IN_BUS_PRES   = 4;
  localparam int IN_BUS_OVP    = 5;
  localparam int IN_P1_POP     = 6;
  localparam int IN_P2_POP     = 7;
  localparam int IN_FAULT      = 8;
  localparam int NUM_IN        = 9;

  // high-side switch count in bypass mode
  localparam int NUM_HIGH_SIDE = 4;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== verification/dpmc_source_model.sv
// pin-level model of the power side: fet pairs, inputs, bus node, faults
`timescale 1ns/100ps
`default_nettype none
module dpmc_source_model (
  input  wire logic                        clk,    // system clock
  input  wire logic [dpmc_pkg::NUM_IN-1:0] cmd,    // levels the scenario wants
  output logic      [dpmc_pkg::NUM_IN-1:0] levels  // levels seen at the pins
);
  // pins follow one clock late, like a slow analog edge, never instantly
  always_ff @(posedge clk)
  begin
    levels <= cmd;  // population, presence and limits of both ports
  end
endmodule
`default_nettype wire

// ===== verification/dpmc_top_bench.sv
// self-checking bench for the power mux control block
`timescale 1ns/100ps
`default_nettype none
module dpmc_top_bench;
  logic        clk, nrst, awv, wv, bry, arv, rry, wdog;  // bus and pulse drives
  logic [11:0] awa, ara;                                 // addresses
  logic [31:0] wd;                                       // write data
  logic [1:0]  bresp, rresp, rsp;                        // responses
  logic [31:0] rdata, rd;                                // read data
  logic        awr, wr_rdy, bv, arr, rv;                 // slave handshakes
  logic        g1, g2, bpd, p1pd, p2pd, blk;             // pin outputs
  logic [3:0]  hss;                                      // high-side switches
  logic [8:0]  cmd, lv;                                  // wanted and actual pins
  int          num_errors, cmp_count;                    // counts
  // 100 ns clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  dpmc_source_model u_dpmc_source_model (.clk(clk), .cmd(cmd), .levels(lv));
  dpmc_top u_dpmc_top (.CLOCK(clk), .NRST(nrst), .AWADDR(awa), .AWVALID(awv),
    .AWREADY(awr), .WDATA(wd), .WSTRB(4'hF), .WVALID(wv), .WREADY(wr_rdy),
    .BRESP(bresp), .BVALID(bv), .BREADY(bry), .ARADDR(ara), .ARVALID(arv),
    .ARREADY(arr), .RDATA(rdata), .RRESP(rresp), .RVALID(rv), .RREADY(rry),
    .PORT1_PRESENT(lv[0]), .PORT2_PRESENT(lv[1]),
    .PORT1_INPUT_OVERVOLTAGE_FAULT(lv[2]), .PORT2_INPUT_OVERVOLTAGE_FAULT(lv[3]),
    .BUS_NODE_PRESENT(lv[4]), .BUS_OVERVOLTAGE_FAULT(lv[5]),
    .PORT1_POPULATED(lv[6]), .PORT2_POPULATED(lv[7]), .CHARGE_FAULT(lv[8]),
    .WATCHDOG_EXPIRED(wdog), .PORT1_GATE_DRIVE(g1), .PORT2_GATE_DRIVE(g2),
    .BUS_PULLDOWN(bpd), .PORT1_PULLDOWN(p1pd), .PORT2_PULLDOWN(p2pd),
    .BLOCKING_SWITCH(blk), .HIGH_SIDE_SWITCHES(hss));
  // one comparison, counted; four-state equality so unknowns never match
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // write: address and data offered together, each released when taken
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
    do
    begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_rdy) wv <= 1'b0;
    end while (!(bry && bv));
    rsp = bresp;
    bry <= 1'b0;
  endtask
  // read: rready held until rvalid is sampled high
  task rdr(input logic [11:0] a);
    @(posedge clk);
    ara <= a; arv <= 1'b1; rry <= 1'b1;
    do
    begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end while (!(rry && rv));
    rd = rdata;
    rsp = rresp;
    rry <= 1'b0;
  endtask
  // let the pin filter and the drive logic settle
  task wt();
    repeat (10) @(posedge clk);
  endtask
  // drive state register and both gate pins against one expectation
  task chkd(input logic [1:0] e);
    wt();
    rdr(12'h004);
    chk("drive state", rd, {30'h0, e});
    chk("gate pins", {30'h0, g2, g1}, {30'h0, e});
  endtask
  task chkc(input logic [7:0] e);
    rdr(12'h000);
    chk("control", rd, {24'h0, e});
  endtask
  task pin(input logic [8:0] c);
    @(posedge clk);
    cmd <= c;
  endtask
  task close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, well beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    close_out();
  end
  // main sequence
  initial
  begin
    num_errors = 0; cmp_count = 0; nrst = 1'b0; awv = 1'b0; wv = 1'b0;
    bry = 1'b0; arv = 1'b0; rry = 1'b0; wdog = 1'b0; awa = 12'h0; ara = 12'h0;
    wd = 32'h0; cmd = 9'h0C3;  // both pairs fitted, both inputs present
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    chkd(2'h1);
    wr(12'h004, 32'h2); chkd(2'h2);
    wr(12'h004, 32'h1); chkd(2'h1);
    wr(12'h000, 32'h1); chkd(2'h0);
    // bus node must be seen present before the enable is lifted, or drive one wins
    pin(9'h0D3); wt(); wr(12'h000, 32'h0); chkd(2'h0);
    pin(9'h0C3); chkd(2'h1);
    wr(12'h000, 32'h2); chkd(2'h0);
    wr(12'h000, 32'h0); chkd(2'h1);
    pin(9'h0C7); chkd(2'h2);
    pin(9'h0C3); chkd(2'h2);
    rdr(12'h008); chk("status", rd, 32'h0C3);
    // reverse power entry, fault, reselect, exit
    wr(12'h000, 32'h4); chkc(8'h05);
    chkd(2'h0);
    wr(12'h000, 32'h4); wr(12'h004, 32'h1); chkd(2'h1);
    pin(9'h0E3); chkd(2'h0);
    chkc(8'h04);
    // reselect only once the filtered fault has cleared, else the write is dropped
    pin(9'h0C3); wt(); wr(12'h004, 32'h1); chkd(2'h1);
    wr(12'h000, 32'h0C); wt(); chk("bus pulldown", {31'h0, bpd}, 32'h1);
    wr(12'h004, 32'h0); chkd(2'h0);
    wr(12'h000, 32'h4); chkc(8'h04);
    @(posedge clk); wdog <= 1'b1;
    @(posedge clk); wdog <= 1'b0;
    wt(); chkc(8'h00);
    chkd(2'h1);
    wr(12'h000, 32'h30); wt();
    chk("pulldowns", {29'h0, p2pd, p1pd, bpd}, 32'h6);
    // bypass mode and the mode change order
    wr(12'h000, 32'hC0); wt(); chk("bypass switches", {27'h0, blk, hss}, 32'h1F);
    pin(9'h1C3); wt(); chkc(8'h80);
    chk("bypass switches", {27'h0, blk, hss}, 32'h0);
    pin(9'h0C3); wr(12'h000, 32'h00); wr(12'h000, 32'h40); wt();
    chk("switched cap switches", {27'h0, blk, hss}, 32'h0);
    // unmapped and read-only places
    rdr(12'h0C0); chk("unmapped read", {rsp, rd[29:0]}, 32'h80000000);
    wr(12'h0C0, 32'h1); chk("unmapped write", {30'h0, rsp}, 32'h2);
    wr(12'h008, 32'h0); rdr(12'h008); chk("status", rd, 32'h0C3);
    close_out();
  end
endmodule
`default_nettype wire
